//--- hdl/agc_adapter_gpio.sv
`timescale 1ns/1ps
module agc_adapter_gpio
  import agc_pkg::*;
#(
  parameter int unsigned PIN_N = AGC_PIN_N
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  output logic if_clk_o,
  input wire logic [AGC_ADDR_W-1:0] if_addr_i,
  input wire logic if_wr_i,
  input wire logic if_rd_i,
  input wire logic [AGC_DATA_W-1:0] if_wdata_i,
  output logic [AGC_DATA_W-1:0] if_rdata_o,
  input wire logic [PIN_N-1:0] gpio_pin_i,
  output logic [PIN_N-1:0] gpio_pin_o,
  output logic [PIN_N-1:0] gpio_pin_oe_n_o
);
  logic [7:0] out_high_reg;
  logic [7:0] out_low_reg;
  logic [7:0] dir_high_reg;
  logic [7:0] dir_low_reg;
  logic [7:0] rdata_next;
  logic if_clk_reg;
  logic [1:0] div_reg;

  // Interface clock is ours, so the partner samples on its edges
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      div_reg <= 2'h0;
      if_clk_reg <= 1'b0;
    end else if (div_reg == AGC_IF_CLK_DIV) begin
      div_reg <= 2'h0;
      if_clk_reg <= ~if_clk_reg;
    end else begin
      div_reg <= div_reg + 2'h1;
    end
  end
  assign if_clk_o = if_clk_reg;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      out_high_reg <= AGC_RST_OUTPUT;
      out_low_reg <= AGC_RST_OUTPUT;
    end else if (if_wr_i) begin
      if (if_addr_i == AGC_OFS_OUTPUT_HIGH) begin
        out_high_reg <= if_wdata_i;
      end
      if (if_addr_i == AGC_OFS_OUTPUT_LOW) begin
        out_low_reg <= if_wdata_i;
      end
    end
  end

  // Pins start as inputs so nothing fights the adapter after reset
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      dir_high_reg <= AGC_RST_DIR;
      dir_low_reg <= AGC_RST_DIR;
    end else if (if_wr_i) begin
      if (if_addr_i == AGC_OFS_DIR_HIGH) begin
        dir_high_reg <= if_wdata_i;
      end
      if (if_addr_i == AGC_OFS_DIR_LOW) begin
        dir_low_reg <= if_wdata_i;
      end
    end
  end

  always_comb begin
    unique case (if_addr_i)
      AGC_OFS_INPUT_HIGH: rdata_next = gpio_pin_i[15:8];
      AGC_OFS_INPUT_LOW: rdata_next = gpio_pin_i[7:0];
      AGC_OFS_OUTPUT_HIGH: rdata_next = out_high_reg;
      AGC_OFS_OUTPUT_LOW: rdata_next = out_low_reg;
      AGC_OFS_DIR_HIGH: rdata_next = dir_high_reg;
      AGC_OFS_DIR_LOW: rdata_next = dir_low_reg;
      default: rdata_next = AGC_RD_UNMAPPED;
    endcase
  end

  // Read data held until next read
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      if_rdata_o <= AGC_RD_UNMAPPED;
    end else if (if_rd_i) begin
      if_rdata_o <= rdata_next;
    end
  end

  agc_pin_drive #(
    .PIN_N(PIN_N)
  ) u_drive (
    .drive_value_i({out_high_reg, out_low_reg}),
    .direction_i({dir_high_reg, dir_low_reg}),
    .pin_o(gpio_pin_o),
    .pin_oe_n_o(gpio_pin_oe_n_o)
  );
endmodule : agc_adapter_gpio

//--- hdl/agc_pin_drive.sv
`timescale 1ns/1ps
module agc_pin_drive
  import agc_pkg::*;
#(
  parameter int unsigned PIN_N = AGC_PIN_N
) (
  input wire logic [PIN_N-1:0] drive_value_i,
  input wire logic [PIN_N-1:0] direction_i,
  output logic [PIN_N-1:0] pin_o,
  output logic [PIN_N-1:0] pin_oe_n_o
);
  genvar g;
  generate
    for (g = 0; g < PIN_N; g++) begin : g_pin
      // Value only reaches the pin while the direction selects output
      assign pin_oe_n_o[g] = (direction_i[g] == AGC_DIR_OUTPUT) ? 1'b0 : 1'b1;
      assign pin_o[g] = drive_value_i[g] & direction_i[g];
    end
  endgenerate
endmodule : agc_pin_drive

//--- hdl/agc_pkg.sv
package agc_pkg;
  localparam int unsigned AGC_ADDR_W = 5;
  localparam int unsigned AGC_DATA_W = 8;
  localparam int unsigned AGC_PIN_N = 16;
  localparam logic [4:0] AGC_OFS_INPUT_HIGH = 5'h08;
  localparam logic [4:0] AGC_OFS_INPUT_LOW = 5'h09;
  localparam logic [4:0] AGC_OFS_OUTPUT_HIGH = 5'h0a;
  localparam logic [4:0] AGC_OFS_OUTPUT_LOW = 5'h0b;
  localparam logic [4:0] AGC_OFS_DIR_HIGH = 5'h0c;
  localparam logic [4:0] AGC_OFS_DIR_LOW = 5'h0d;
  localparam logic [7:0] AGC_RST_OUTPUT = 8'h00;
  localparam logic [7:0] AGC_RST_DIR = 8'h00;
  localparam logic [7:0] AGC_RD_UNMAPPED = 8'h00;
  localparam logic AGC_DIR_INPUT = 1'b0;
  localparam logic AGC_DIR_OUTPUT = 1'b1;
  localparam logic [1:0] AGC_IF_CLK_DIV = 2'h1;
endpackage : agc_pkg

//--- tb/agc_adapter_gpio_tb.sv
`timescale 1ns/1ps
module agc_adapter_gpio_tb;
  logic ref_clk_i=0,resetn_i=0,if_wr_i=0,if_rd_i=0,if_clk_o;
  logic [4:0] if_addr_i=0,a;
  logic [7:0] if_wdata_i=0,if_rdata_o,m[4]='{default:0};
  logic [15:0] e;
  logic [15:0] gpio_pin_i,gpio_pin_o,gpio_pin_oe_n_o;
  logic [31:0] r=32'h6448;
  int miscompares=0,n_tests=0;
  agc_adapter_gpio i_dut(.*);
  agc_adapter_model i_adp(.*);
  initial forever #20 ref_clk_i=~ref_clk_i;
  function automatic logic [31:0] lf(logic [31:0] s);
    return {s[30:0],s[31]^s[21]^s[1]^s[0]};
  endfunction : lf
  task automatic chk(logic [15:0] g,x);
    n_tests++;
    if(g!==x) begin miscompares++; $display("ERROR %0t %h %h",$time,g,x); end
  endtask : chk
  task automatic acc(logic w,logic [4:0] ad,logic [7:0] dt);
    @(posedge ref_clk_i) {if_wr_i,if_rd_i,if_addr_i,if_wdata_i}<={w,!w,ad,dt};
    @(posedge ref_clk_i) {if_wr_i,if_rd_i}<=2'h0;
    e=gpio_pin_i;
    #1;
  endtask : acc
  task automatic print_verdict;
    $display("tests %0d mismatches %0d",n_tests,miscompares);
    if(miscompares==0&&n_tests>0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  initial begin
    #50000;
    miscompares++;
    print_verdict;
  end
  initial begin
    repeat(4) @(posedge ref_clk_i);
    resetn_i<=1;
    #1 chk(gpio_pin_oe_n_o,16'hffff);
    for(int i=10;i<14;i++) begin acc(0,i[4:0],0); chk(if_rdata_o,0); end
    // Corner: all low pins driven before random mix
    acc(1,5'h0d,8'hff);
    m[3]=8'hff;
    repeat(60) begin
      r=lf(r);
      a=5'h0a+r[1:0];
      acc(1,a,r[15:8]);
      m[a-10]=r[15:8];
      chk(gpio_pin_oe_n_o,~{m[2],m[3]});
      chk(gpio_pin_o,{m[0],m[1]}&{m[2],m[3]});
      acc(0,a,0);
      chk(if_rdata_o,m[a-10]);
      acc(0,5'h09,0);
      chk(if_rdata_o,e[7:0]);
      acc(0,5'h08,0);
      chk(if_rdata_o,e[15:8]);
    end
    // Corner: input registers ignore writes
    acc(1,5'h08,8'h5a);
    acc(1,5'h09,8'ha5);
    chk(gpio_pin_oe_n_o,~{m[2],m[3]});
    chk(gpio_pin_o,{m[0],m[1]}&{m[2],m[3]});
    acc(0,5'h1f,0);
    chk(if_rdata_o,0);
    print_verdict;
  end
endmodule : agc_adapter_gpio_tb

//--- tb/agc_adapter_model.sv
`timescale 1ns/1ps
module agc_adapter_model(input wire logic ref_clk_i,input wire logic [15:0] gpio_pin_o,
  gpio_pin_oe_n_o,output logic [15:0] gpio_pin_i);
  logic [15:0] s=16'h5a3c;
  // Own drive moves each cycle so stale reads show
  always @(negedge ref_clk_i) s<={s[14:0],~s[15]^s[4]};
  assign gpio_pin_i=gpio_pin_o&~gpio_pin_oe_n_o|s&gpio_pin_oe_n_o;
endmodule : agc_adapter_model

//--- tb/agc_gpio_asserts.sv
`timescale 1ns/1ps
module agc_gpio_asserts import agc_pkg::*; #(int PIN_N=AGC_PIN_N)(
  input wire logic ref_clk_i,resetn_i,if_clk_o,if_wr_i,if_rd_i,
  input wire logic [4:0] if_addr_i,input wire logic [7:0] if_wdata_i,if_rdata_o,
  input wire logic [PIN_N-1:0] gpio_pin_i,gpio_pin_o,gpio_pin_oe_n_o);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  wire [7:0] d=if_wdata_i;
  wire [4:0] ad=if_addr_i;
  dir_hi_a: assert property(if_wr_i&&ad==5'h0c|=>gpio_pin_oe_n_o[15:8]==~$past(d))
    else $error("dir");
  dir_lo_a: assert property(if_wr_i&&ad==5'h0d|=>gpio_pin_oe_n_o[7:0]==~$past(d))
    else $error("dir");
  out_hi_a: assert property(if_wr_i&&ad==5'h0a|=>gpio_pin_o[15:8]==($past(d)&~gpio_pin_oe_n_o[15:8]))
    else $error("out");
  out_lo_a: assert property(if_wr_i&&ad==5'h0b|=>gpio_pin_o[7:0]==($past(d)&~gpio_pin_oe_n_o[7:0]))
    else $error("out");
  input_off_a: assert property(!(|(gpio_pin_o&gpio_pin_oe_n_o))) else $error("undriven");
  in_lo_a: assert property(if_rd_i&&ad==5'h09|=>if_rdata_o==$past(gpio_pin_i[7:0]))
    else $error("in");
  rst_val_a: assert property($rose(resetn_i)|->&gpio_pin_oe_n_o&&gpio_pin_o==0)
    else $error("rst");
  if_clk_a: assert property($rose(if_clk_o)|=>if_clk_o##1!if_clk_o) else $error("clk");
endmodule : agc_gpio_asserts
bind agc_adapter_gpio agc_gpio_asserts #(.PIN_N(PIN_N)) i_chk(.*);
